// ==== core/dic_params.svh ====
// Constants for the display interface control command decoder.
`ifndef DIC_PARAMS_SVH
`define DIC_PARAMS_SVH
`define DIC_CMD_LAMP 8'hf1
`define DIC_CMD_IFACE 8'hf6
`define DIC_LAMP_KEY 8'h50
`define DIC_LAMP_EN_OFF_BIT 6
`define DIC_LAMP_EN_LVL_BIT 5
`define DIC_LAMP_DIM_OFF_BIT 4
`define DIC_LAMP_DIM_LVL_BIT 3
`define DIC_P1_MASK 8'h33
`define DIC_P2_MASK 8'h2f
`define DIC_P1_RESET 8'h00
`define DIC_P2_RESET 8'h00
`define DIC_LAMP_RESET 4'h0
`define DIC_ENDIAN_BIT 5
`define DIC_RAMSEL_BIT 1
`define DIC_RGBW_BIT 0
`define DIC_FMT_262K 3'h6
`define DIC_FMT_65K 3'h5
`define DIC_REG_CMD 8'h00
`define DIC_REG_P1 8'h04
`define DIC_REG_P2 8'h08
`define DIC_REG_STATUS 8'h0c
`define DIC_REG_CFG 8'h10
`endif

// ==== core/dic_pkg.sv ====
// Types shared by both ends of the display interface control link.
package dic_pkg;
    typedef enum logic [1:0] {
        DIC_OP_INTERNAL,
        DIC_OP_RGB,
        DIC_OP_VSYNC,
        DIC_OP_DISABLED
    } dic_op_mode_t;
    typedef enum logic [1:0] {
        DIC_BUS_18,
        DIC_BUS_16,
        DIC_BUS_6,
        DIC_BUS_NONE
    } dic_bus_t;
endpackage : dic_pkg

// ==== core/dic_link_if.sv ====
// Byte-wide command link between host controller and display device.
`timescale 1ns/1ps
`default_nettype none
interface dic_link_if;
    logic wr_stb;
    logic is_param;
    logic [7:0] data;
    logic ext_cmd_enable;
    modport host (output wr_stb, output is_param, output data,
        output ext_cmd_enable);
    modport device (input wr_stb, input is_param, input data,
        input ext_cmd_enable);
endinterface : dic_link_if
`default_nettype wire

// ==== core/dic_expand.sv ====
// Expansion of a 16 bpp pixel to 18 bpp with selectable LSB fill.
`timescale 1ns/1ps
`default_nettype none
module dic_expand (
    input wire logic [1:0] expand_format_sel,
    input wire logic [15:0] pix_in,
    output logic [17:0] pix_out
);
    wire [4:0] r = pix_in[15:11];
    wire [5:0] g = pix_in[10:5];
    wire [4:0] b = pix_in[4:0];
    // Each channel keeps its own exception; for expand_format_sel 0 to 2 full scale stays full scale
    // and black stays black, while 3 takes g[0] as the LSB when the channel equals g[5:1].
    wire r_ones = (r == 5'h1f);
    wire b_ones = (b == 5'h1f);
    wire r_zero = (r == 5'h00);
    wire b_zero = (b == 5'h00);
    wire r_eq_g = (r == g[5:1]);
    wire b_eq_g = (b == g[5:1]);
    wire r_lsb = (r_eq_g) ? g[0] : r[4];
    wire b_lsb = (b_eq_g) ? g[0] : b[0];
    logic [1:0] fill;
    always_comb begin
        unique case (expand_format_sel)
            2'h0: fill = {r[4], b[4]};
            2'h1: fill = {r_ones, b_ones};
            2'h2: fill = {!r_zero, !b_zero};
            2'h3: fill = {r_lsb, b_lsb};
        endcase
    end
    assign pix_out = {r, fill[1], g, b, fill[0]};
endmodule : dic_expand
`default_nettype wire

// ==== core/dic_device.sv ====
// Device end: decodes lamp and interface control commands.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dic_params.svh"
module dic_device
    import dic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    dic_link_if.device link,
    input wire logic sw_reset,
    input wire logic sleep_in,
    input wire logic mcu_65k_narrow,
    input wire logic [2:0] pixel_format_field,
    input wire logic [15:0] pix_in,
    output logic [1:0] transfer_method_sel,
    output logic [1:0] expand_format_sel,
    output logic lsb_first,
    output dic_op_mode_t display_op_mode,
    output logic ram_port_sel,
    output dic_bus_t rgb_bus,
    output logic [1:0] rgb_transfers,
    output logic lamp_enable_pin_o,
    output logic lamp_enable_pin_oe,
    output logic lamp_dim_pin_o,
    output logic lamp_dim_pin_oe,
    output logic [17:0] pix_out
);
    typedef enum logic [2:0] {
        DIC_IDLE, DIC_LAMP_P1, DIC_LAMP_P2, DIC_IF_P1, DIC_IF_P2
    } dic_dev_state_t;
    dic_dev_state_t state, next_state;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [3:0] lamp;
    logic [17:0] pix_exp;
    wire cmd_stb = link.wr_stb && !link.is_param;
    wire par_stb = link.wr_stb && link.is_param;
    wire ext_ok = link.ext_cmd_enable;
    wire lamp_go = cmd_stb && ext_ok && !sleep_in
        && (link.data == `DIC_CMD_LAMP);
    wire if_go = cmd_stb && ext_ok
        && (link.data == `DIC_CMD_IFACE);
    wire key_ok = par_stb && (link.data == `DIC_LAMP_KEY);
    wire p1_wr = par_stb && (state == DIC_IF_P1);
    wire p2_wr = par_stb && (state == DIC_IF_P2);
    wire lamp_wr = par_stb && (state == DIC_LAMP_P2);
    wire [1:0] mode_bits = p2[3:2];
    wire rgbw = p2[`DIC_RGBW_BIT];
    wire fmt_ok = (pixel_format_field == `DIC_FMT_262K)
        || (pixel_format_field == `DIC_FMT_65K);
    wire [1:0] next_transfers = rgbw ? 2'h3 : 2'h1;
    dic_bus_t next_bus;
    assign next_bus = !fmt_ok ? DIC_BUS_NONE
        : rgbw ? DIC_BUS_6
        : (pixel_format_field == `DIC_FMT_262K) ? DIC_BUS_18
        : DIC_BUS_16;
    always_comb begin
        next_state = state;
        if (cmd_stb) begin
            // Any command aborts an unfinished parameter sequence.
            next_state = lamp_go ? DIC_LAMP_P1
                : if_go ? DIC_IF_P1 : DIC_IDLE;
        end else if (par_stb) begin
            unique case (state)
                DIC_IDLE: next_state = DIC_IDLE;
                DIC_LAMP_P1: next_state = key_ok ? DIC_LAMP_P2 : DIC_IDLE;
                DIC_LAMP_P2: next_state = DIC_IDLE;
                DIC_IF_P1: next_state = DIC_IF_P2;
                DIC_IF_P2: next_state = DIC_IDLE;
            endcase
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= DIC_IDLE;
            p1 <= `DIC_P1_RESET;
            p2 <= `DIC_P2_RESET;
            lamp <= `DIC_LAMP_RESET;
        end else if (sw_reset) begin
            state <= DIC_IDLE;
            p1 <= `DIC_P1_RESET;
            p2 <= `DIC_P2_RESET;
            lamp <= `DIC_LAMP_RESET;
        end else begin
            state <= next_state;
            if (p1_wr) p1 <= link.data & `DIC_P1_MASK;
            if (p2_wr) p2 <= link.data & `DIC_P2_MASK;
            if (lamp_wr) lamp <= {link.data[`DIC_LAMP_EN_OFF_BIT],
                link.data[`DIC_LAMP_EN_LVL_BIT],
                link.data[`DIC_LAMP_DIM_OFF_BIT],
                link.data[`DIC_LAMP_DIM_LVL_BIT]};
        end
    end
    dic_expand u_expand (
        .expand_format_sel(p1[5:4]),
        .pix_in(pix_in),
        .pix_out(pix_exp)
    );
    // Every output is registered so pin timing does not depend on decode.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            transfer_method_sel <= 2'h0;
            expand_format_sel <= 2'h0;
            lsb_first <= 1'b0;
            display_op_mode <= DIC_OP_INTERNAL;
            ram_port_sel <= 1'b0;
            rgb_bus <= DIC_BUS_18;
            rgb_transfers <= 2'h1;
            lamp_enable_pin_o <= 1'b0;
            lamp_enable_pin_oe <= 1'b1;
            lamp_dim_pin_o <= 1'b0;
            lamp_dim_pin_oe <= 1'b1;
            pix_out <= 18'h00000;
        end else begin
            transfer_method_sel <= p1[1:0];
            expand_format_sel <= p1[5:4];
            lsb_first <= p2[`DIC_ENDIAN_BIT] && mcu_65k_narrow;
            display_op_mode <= dic_op_mode_t'(mode_bits);
            ram_port_sel <= p2[`DIC_RAMSEL_BIT];
            rgb_bus <= next_bus;
            rgb_transfers <= next_transfers;
            lamp_enable_pin_oe <= !lamp[3];
            lamp_enable_pin_o <= lamp[2];
            lamp_dim_pin_oe <= !lamp[1];
            lamp_dim_pin_o <= lamp[0];
            pix_out <= pix_exp;
        end
    end
endmodule : dic_device
`default_nettype wire

// ==== core/dic_host.sv ====
// Host end: AXI4-Lite slave that sends command and parameter bytes.
`timescale 1ns/1ps
`default_nettype none
`include "dic_params.svh"
module dic_host
    import dic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    dic_link_if.host link,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic [7:0] last_cmd, last_p1, last_p2;
    logic refused;
    wire do_wr = aw_held && w_held && !s_axi_bvalid;
    wire hit_cmd = (aw_addr == `DIC_REG_CMD);
    wire hit_p1 = (aw_addr == `DIC_REG_P1);
    wire hit_p2 = (aw_addr == `DIC_REG_P2);
    wire hit_cfg = (aw_addr == `DIC_REG_CFG);
    wire hit_any = hit_cmd || hit_p1 || hit_p2 || hit_cfg;
    wire [1:0] cur_mode = last_p2[3:2];
    wire [1:0] new_mode = w_byte[3:2];
    // Refuse a direct hop between two non-internal modes and RGB width change while running.
    wire bad_p2 = hit_p2 && last_cmd == `DIC_CMD_IFACE
        && ((cur_mode != 2'h0 && new_mode != 2'h0
        && cur_mode != new_mode)
        || (cur_mode == 2'h1 && new_mode == 2'h1
        && w_byte[`DIC_RGBW_BIT] != last_p2[`DIC_RGBW_BIT]));
    wire send = do_wr && w_lane0 && (hit_cmd || hit_p1 || hit_p2) && !bad_p2;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            link.wr_stb <= 1'b0;
            link.is_param <= 1'b0;
            link.data <= 8'h00;
            link.ext_cmd_enable <= 1'b0;
            last_cmd <= 8'h00;
            last_p1 <= 8'h00;
            last_p2 <= 8'h00;
            refused <= 1'b0;
        end else begin
            link.wr_stb <= send;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_wr) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (hit_any && !bad_p2) ? 2'h0 : 2'h2;
                refused <= bad_p2;
                if (hit_cfg && w_lane0) link.ext_cmd_enable <= w_byte[0];
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (send) begin
                link.is_param <= !hit_cmd;
                link.data <= w_byte;
                if (hit_cmd) last_cmd <= w_byte;
                if (hit_p1) last_p1 <= w_byte;
                if (hit_p2) last_p2 <= w_byte;
            end
        end
    end
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    wire [31:0] rd_word = (s_axi_araddr == `DIC_REG_CMD) ? {24'h0, last_cmd}
        : (s_axi_araddr == `DIC_REG_P1) ? {24'h0, last_p1}
        : (s_axi_araddr == `DIC_REG_P2) ? {24'h0, last_p2}
        : (s_axi_araddr == `DIC_REG_STATUS) ? {31'h0, refused}
        : (s_axi_araddr == `DIC_REG_CFG)
        ? {31'h0, link.ext_cmd_enable} : 32'h0;
    wire rd_hit = (s_axi_araddr == `DIC_REG_CMD)
        || (s_axi_araddr == `DIC_REG_P1) || (s_axi_araddr == `DIC_REG_P2)
        || (s_axi_araddr == `DIC_REG_STATUS) || (s_axi_araddr == `DIC_REG_CFG);
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : dic_host
`default_nettype wire

// ==== dv/dic_link_props.sv ====
// Assertions on the link and on the device outputs of the control pair.
`timescale 1ns/1ps
`default_nettype none
module dic_link_props
    import dic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_stb,
    input wire logic is_param,
    input wire logic [7:0] data,
    input wire logic ext_cmd_enable,
    input wire logic sleep_in,
    input var dic_op_mode_t display_op_mode,
    input var dic_bus_t rgb_bus,
    input wire logic [1:0] rgb_transfers,
    input wire logic lamp_enable_pin_o,
    input wire logic lamp_enable_pin_oe,
    input wire logic lamp_dim_pin_oe
);
    logic [7:0] cmd;
    logic [1:0] pn;
    logic [1:0] mode;
    logic width;
    logic [7:0] lamp;
    logic key_ok;
    wire p2_hit = wr_stb && is_param && cmd == 8'hf6 && pn == 2'd1;
    wire lamp_hit = wr_stb && is_param && cmd == 8'hf1 && pn == 2'd1 && key_ok;
    wire lamp_take = lamp_hit && ext_cmd_enable && !sleep_in;
    wire rgb_on = display_op_mode == DIC_OP_RGB;

    // Shadow of what the host has sent, so outputs can be tied to bytes.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd <= 8'h00;
            pn <= 2'd0;
            mode <= 2'd0;
            width <= 1'b0;
            lamp <= 8'h00;
            key_ok <= 1'b0;
        end else if (wr_stb) begin
            cmd <= is_param ? cmd : data;
            pn <= is_param ? pn + 2'd1 : 2'd0;
            key_ok <= (is_param && pn == 2'd0) ? data == 8'h50 : key_ok;
            mode <= p2_hit ? data[3:2] : mode;
            width <= p2_hit ? data[0] : width;
            lamp <= lamp_take ? data : lamp;
        end
    end

    sequence s_iface_p2;
        p2_hit;
    endsequence
    sequence s_lamp_pin;
        lamp_hit;
    endsequence

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_stb_single: assert property (wr_stb |=> !wr_stb)
        else $error("link strobe wider than one cycle");
    a_no_rgb_vsync: assert property (s_iface_p2 ##0 (mode == 2'b01)
        |-> data[3:2] != 2'b10) else $error("direct move from RGB to VSYNC");
    a_no_vsync_rgb: assert property (s_iface_p2 ##0 (mode == 2'b10)
        |-> data[3:2] != 2'b01) else $error("direct move from VSYNC to RGB");
    a_width_locked: assert property (s_iface_p2 ##0
        (mode == 2'b01 && data[3:2] == 2'b01) |-> data[0] == width)
        else $error("bus width changed during RGB operation");
    a_mode_applied: assert property (s_iface_p2 ##0 ext_cmd_enable
        |=> ##[0:2] (2'(display_op_mode) == mode))
        else $error("operation mode does not follow second parameter");
    a_lamp_drive: assert property (s_lamp_pin ##0 lamp_take
        |=> ##[0:2] (lamp_enable_pin_oe == !lamp[6]
        && (lamp[6] || lamp_enable_pin_o == lamp[5])
        && lamp_dim_pin_oe == !lamp[4])) else $error("lamp pins wrong");
    a_lamp_refused: assert property (s_lamp_pin ##0
        (!ext_cmd_enable || sleep_in)
        |=> $stable({lamp_enable_pin_oe, lamp_dim_pin_oe}) [*3])
        else $error("refused lamp command changed the pins");
    a_reset_lamp: assert property ($fell(rst) |-> lamp_enable_pin_oe
        && !lamp_enable_pin_o && lamp_dim_pin_oe)
        else $error("lamp pins not driving low after reset");
    a_six_bit: assert property (rgb_on && rgb_bus == DIC_BUS_6
        |-> rgb_transfers == 2'd3) else $error("six bit bus needs three");
    a_wide_bus: assert property (rgb_on && rgb_bus != DIC_BUS_6
        && rgb_bus != DIC_BUS_NONE |-> rgb_transfers == 2'd1)
        else $error("wide bus needs one transfer");
endmodule : dic_link_props
`default_nettype wire

// ==== dv/display_interface_control_tb.sv ====
// Self-checking bench joining the host and device ends of the link.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    mismatches++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module display_interface_control_tb
    import dic_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic sw_reset = 1'b0, sleep_in = 1'b0, mcu_65k_narrow = 1'b0, ext = 1'b0;
    logic [2:0] pixel_format_field = 3'h6;
    logic [15:0] pix_in = 16'h0000;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, lsb_first, ram_port_sel;
    logic [1:0] s_axi_bresp, s_axi_rresp, transfer_method_sel;
    logic [1:0] expand_format_sel, rgb_transfers;
    logic lamp_enable_pin_o, lamp_enable_pin_oe, lamp_dim_pin_o;
    logic lamp_dim_pin_oe;
    logic [17:0] pix_out;
    dic_op_mode_t display_op_mode;
    dic_bus_t rgb_bus;
    logic [7:0] cp1 = 8'h00, cp2 = 8'h00;
    logic [3:0] le = 4'h0;
    logic [33:0] expq [$];
    logic [33:0] exp_e;
    int mismatches = 0, num_checks = 0;
    logic [7:0] pins [3] = '{8'h30, 8'h00, 8'h48};
    // Each step: narrow MCU mode, pixel format, accepted, P1, P2.
    logic [20:0] steps [10] = '{{4'h6, 1'b1, 16'hcd04},
        {4'h5, 1'b1, 16'h0106}, {4'h5, 1'b0, 16'h0108},
        {4'h5, 1'b0, 16'h0107}, {4'h6, 1'b1, 16'h1200},
        {4'h6, 1'b1, 16'h1205}, {4'h6, 1'b1, 16'h2300},
        {4'he, 1'b1, 16'h2328}, {4'hd, 1'b1, 16'h2020},
        {4'h5, 1'b1, 16'h202c}};

    dic_link_if link ();
    dic_device i_dic_device (.ref_clk, .rst, .link, .sw_reset, .sleep_in,
        .mcu_65k_narrow, .pixel_format_field, .pix_in, .transfer_method_sel,
        .expand_format_sel, .lsb_first, .display_op_mode, .ram_port_sel,
        .rgb_bus, .rgb_transfers, .lamp_enable_pin_o, .lamp_enable_pin_oe,
        .lamp_dim_pin_o, .lamp_dim_pin_oe, .pix_out);
    dic_host i_dic_host (.ref_clk, .rst, .link, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    dic_link_props i_dic_link_props (.ref_clk, .rst, .wr_stb(link.wr_stb),
        .is_param(link.is_param), .data(link.data), .sleep_in,
        .ext_cmd_enable(link.ext_cmd_enable), .display_op_mode, .rgb_bus,
        .rgb_transfers, .lamp_enable_pin_o, .lamp_enable_pin_oe,
        .lamp_dim_pin_oe);

    always #2.5 ref_clk = ~ref_clk;

    // Ready and valid come from flops, so a level seen at the falling edge
    // is the one the next rising edge takes.
    always @(negedge ref_clk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            exp_e = expq.pop_front();
            `CHK("bresp", exp_e[33:32], s_axi_bresp)
        end
        if (s_axi_rvalid && s_axi_rready) begin
            exp_e = expq.pop_front();
            `CHK("rresp", exp_e[33:32], s_axi_rresp)
            `CHK("rdata", exp_e[31:0], s_axi_rdata)
        end
    end

    task automatic axw(input logic [7:0] a, d, input logic [1:0] er);
        logic ah, wh, bh;
        expq.push_back({er, 32'h0});
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge ref_clk);
            ah = s_axi_awready;
            wh = s_axi_wready;
            bh = s_axi_bvalid;
            @(posedge ref_clk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) s_axi_bready <= 1'b0;
        end while (!bh);
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [31:0] ed,
            input logic [1:0] er);
        logic ah, rh;
        expq.push_back({er, ed});
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge ref_clk);
            ah = s_axi_arready;
            rh = s_axi_rvalid;
            @(posedge ref_clk);
            if (ah) s_axi_arvalid <= 1'b0;
            if (rh) s_axi_rready <= 1'b0;
        end while (!rh);
    endtask : axr

    task automatic lamp_chk();
        repeat (4) @(negedge ref_clk);
        `CHK("en_oe", !le[3], lamp_enable_pin_oe)
        if (!le[3]) `CHK("en_o", le[2], lamp_enable_pin_o)
        `CHK("dim_oe", !le[1], lamp_dim_pin_oe)
        if (!le[1]) `CHK("dim_o", le[0], lamp_dim_pin_o)
    endtask : lamp_chk

    task automatic lamp(input logic [7:0] key, pin);
        axw(8'h00, 8'hf1, 2'b00);
        axw(8'h04, key, 2'b00);
        axw(8'h08, pin, 2'b00);
        if (ext && !sleep_in && key == 8'h50) le = pin[6:3];
        lamp_chk();
    endtask : lamp

    task automatic ifc(input logic [7:0] p1, p2, input logic ok);
        axw(8'h00, 8'hf6, 2'b00);
        axw(8'h04, p1, 2'b00);
        axw(8'h08, p2, ok ? 2'b00 : 2'b10);
        cp1 = p1 & 8'h33;
        if (ok) cp2 = p2 & 8'h2f;
        repeat (4) @(negedge ref_clk);
        `CHK("method", cp1[1:0], transfer_method_sel)
        `CHK("expand", cp1[5:4], expand_format_sel)
        `CHK("mode", cp2[3:2], display_op_mode)
        `CHK("ramsel", cp2[1], ram_port_sel)
        `CHK("lsb", cp2[5] & mcu_65k_narrow, lsb_first)
        if (cp2[3:2] == 2'b01) begin
            `CHK("xfers", cp2[0] ? 2'd3 : 2'd1, rgb_transfers)
            `CHK("bus", cp2[0] ? 2'd2 : 2'(pixel_format_field[0]), rgb_bus)
        end
    endtask : ifc

    function automatic logic fill(input logic [1:0] f, input logic [4:0] c);
        return f == 2'b00 ? c[4] : (f == 2'b01 ? &c : |c);
    endfunction : fill

    task automatic pix_chk();
        logic [15:0] p;
        logic [17:0] e;
        p = 16'($urandom);
        e = {p[15:11], fill(cp1[5:4], p[15:11]), p[10:5], p[4:0],
            fill(cp1[5:4], p[4:0])};
        @(posedge ref_clk);
        pix_in <= p;
        repeat (2) @(negedge ref_clk);
        `CHK("pix", e, pix_out)
    endtask : pix_chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        #200000;
        mismatches++;
        conclude();
    end

    initial begin
        void'($urandom(32'h4294));
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        `CHK("rst_mode", DIC_OP_INTERNAL, display_op_mode)
        lamp_chk();
        $display("test reset done");
        lamp(8'h50, 8'h48);
        axw(8'h10, 8'h01, 2'b00);
        ext = 1'b1;
        axr(8'h10, 32'h1, 2'b00);
        foreach (pins[i]) lamp(8'h50, pins[i]);
        lamp(8'h51, 8'h30);
        sleep_in <= 1'b1;
        lamp(8'h50, 8'h30);
        sleep_in <= 1'b0;
        $display("test lamp done");
        foreach (steps[i]) begin
            mcu_65k_narrow <= steps[i][20];
            pixel_format_field <= steps[i][19:17];
            ifc(steps[i][15:8], steps[i][7:0], steps[i][16]);
            pix_chk();
            if (!steps[i][16]) axr(8'h0c, 32'h1, 2'b00);
        end
        axr(8'h20, 32'h0, 2'b10);
        $display("test interface done");
        @(posedge ref_clk);
        sw_reset <= 1'b1;
        @(posedge ref_clk);
        sw_reset <= 1'b0;
        cp1 = 8'h00;
        cp2 = 8'h00;
        le = 4'h0;
        lamp_chk();
        `CHK("sw_mode", DIC_OP_INTERNAL, display_op_mode)
        `CHK("sw_method", 2'b00, transfer_method_sel)
        $display("test soft reset done");
        conclude();
    end
endmodule : display_interface_control_tb
`default_nettype wire
